/* logic/tocu_timer_compare.sv */
// Purpose: 8-bit timer counter with two output compare channels and port override
// Assumes: timer_tick is a one-cycle pulse per timer clock, synchronous to hclk
// Notes: Zero-wait AHB-Lite slave; read data reflects writes of the previous data phase
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`default_nettype none

// Function
// - Compare counter with both compare registers always
// - Compare flag set one timer tick later
// - Enabled flag raises its interrupt request
// - Flag cleared by service or writing one
// - PWM modes buffer compare, update at top/bottom
// - CPU reaches buffer in PWM, else register
// - Force strobe updates output outside PWM modes, no flag/counter
// - Counter write blocks match next timer tick
// - Output state kept across mode changes
// - Output action setting is unbuffered
// - Reset clears output state registers
// - Nonzero action overrides port data, not direction
// - Override identical in all waveform modes
// - Action zero never changes output state
// - Action picks polarity/set/clear, never counting
// - Mode 0 increments and wraps FF to 00
// - Overflow flag set as counter becomes zero, except on the compare A clear of mode 2
// - Normal mode accepts counter writes anytime
// - Mode 2 clears counter on compare A
// - Modes 3,7 fast PWM; 1,5 phase correct
// - CPU counter write beats clear or count
module tocu_timer_compare
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Timer clock from prescaler
	input wire logic timer_tick,
	// Interrupt service acknowledge and requests
	input wire tocu_pkg::tocu_irq_t irq_ack,
	output tocu_pkg::tocu_irq_t irq_req,
	// Compare output pins
	output tocu_pkg::tocu_pins_t pins
);

	tocu_pkg::tocu_state_t s_reg;
	tocu_pkg::tocu_state_t s_next;

	function automatic logic wgm_is_fast(input logic [2:0] m);
		wgm_is_fast = (m == tocu_pkg::TOCU_WGM_FAST_MAX) || (m == tocu_pkg::TOCU_WGM_FAST_CMP);
	endfunction

	function automatic logic wgm_is_pc(input logic [2:0] m);
		wgm_is_pc = (m == tocu_pkg::TOCU_WGM_PC_MAX) || (m == tocu_pkg::TOCU_WGM_PC_CMP);
	endfunction

	function automatic logic [31:0] reg_read(input tocu_pkg::tocu_state_t st, input logic [7:0] a);
		logic pwm;
		pwm = wgm_is_fast(st.wgm) || wgm_is_pc(st.wgm);
		reg_read = 32'h0000_0000;
		unique case (a)
			tocu_pkg::TOCU_ADDR_CTRL:
			begin
				reg_read[tocu_pkg::TOCU_CTRL_WGM_LSB +: 3] = st.wgm;
				reg_read[tocu_pkg::TOCU_CTRL_ACT_A_LSB +: 2] = st.act[0];
				reg_read[tocu_pkg::TOCU_CTRL_ACT_B_LSB +: 2] = st.act[1];
			end
			tocu_pkg::TOCU_ADDR_COUNT: reg_read[7:0] = st.count;
			tocu_pkg::TOCU_ADDR_CMP_A: reg_read[7:0] = pwm ? st.cbuf[0] : st.cmp[0];
			tocu_pkg::TOCU_ADDR_CMP_B: reg_read[7:0] = pwm ? st.cbuf[1] : st.cmp[1];
			tocu_pkg::TOCU_ADDR_FLAGS: reg_read[2:0] = st.flags;
			tocu_pkg::TOCU_ADDR_IRQ_EN: reg_read[2:0] = st.irqen;
			tocu_pkg::TOCU_ADDR_PORT:
			begin
				reg_read[tocu_pkg::TOCU_PORT_DATA_A] = st.port_data[0];
				reg_read[tocu_pkg::TOCU_PORT_DIR_A] = st.port_dir[0];
				reg_read[tocu_pkg::TOCU_PORT_DATA_B] = st.port_data[1];
				reg_read[tocu_pkg::TOCU_PORT_DIR_B] = st.port_dir[1];
			end
			default: reg_read = 32'h0000_0000;
		endcase
	endfunction

	always_comb
	begin
		logic wr;
		logic wr_ctrl;
		logic wr_count;
		logic is_fast;
		logic is_pc;
		logic is_pwm;
		logic [7:0] top;
		logic at_top;
		logic restart;
		logic turn_top;
		logic [1:0] eq;
		logic [1:0] match;
		logic [1:0] force_hit;
		logic [2:0] flag_set;
		logic [2:0] flag_clr;
		logic [1:0] a;
		s_next = s_reg;
		wr = s_reg.ph_valid && s_reg.ph_write;
		wr_ctrl = wr && (s_reg.ph_addr == tocu_pkg::TOCU_ADDR_CTRL);
		wr_count = wr && (s_reg.ph_addr == tocu_pkg::TOCU_ADDR_COUNT);
		force_hit = 2'h0;
		flag_set = 3'h0;
		flag_clr = 3'h0;
		restart = 1'b0;
		turn_top = 1'b0;
		is_fast = 1'b0;
		is_pc = 1'b0;
		is_pwm = 1'b0;
		top = tocu_pkg::TOCU_MAX;
		at_top = 1'b0;
		eq = 2'h0;
		match = 2'h0;
		a = tocu_pkg::TOCU_ACT_NONE;

		// Control write; action fields take effect at once
		if (wr_ctrl)
		begin
			s_next.wgm = hwdata[tocu_pkg::TOCU_CTRL_WGM_LSB +: 3];
			s_next.act[0] = hwdata[tocu_pkg::TOCU_CTRL_ACT_A_LSB +: 2];
			s_next.act[1] = hwdata[tocu_pkg::TOCU_CTRL_ACT_B_LSB +: 2];
		end
		is_fast = wgm_is_fast(s_next.wgm);
		is_pc = wgm_is_pc(s_next.wgm);
		is_pwm = is_fast || is_pc;
		if (wr_ctrl && !is_pwm)
		begin
			force_hit[0] = hwdata[tocu_pkg::TOCU_CTRL_FORCE_A];
			force_hit[1] = hwdata[tocu_pkg::TOCU_CTRL_FORCE_B];
		end

		// TOP of the count sequence
		if ((s_next.wgm == tocu_pkg::TOCU_WGM_FAST_CMP) || (s_next.wgm == tocu_pkg::TOCU_WGM_PC_CMP)
			|| (s_next.wgm == tocu_pkg::TOCU_WGM_CTC))
		begin
			top = s_reg.cmp[0];
		end
		else
		begin
			top = tocu_pkg::TOCU_MAX;
		end
		at_top = (s_reg.count == top);

		// Matches count only on a timer tick, not in a blocked tick
		for (int i = 0; i < 2; i++)
		begin
			eq[i] = (s_reg.count == s_reg.cmp[i]);
			match[i] = timer_tick && eq[i] && !s_reg.block;
		end

		// Counting sequence, driven by waveform mode only
		if (timer_tick)
		begin
			if (is_fast)
			begin
				if (at_top)
				begin
					s_next.count = tocu_pkg::TOCU_BOTTOM;
					restart = 1'b1;
					flag_set[tocu_pkg::TOCU_FLAG_OVF] = 1'b1;
				end
				else
				begin
					s_next.count = 8'(s_reg.count + 8'h01);
				end
			end
			else if (is_pc)
			begin
				if (!s_reg.down)
				begin
					if (s_reg.count >= top)
					begin
						s_next.down = 1'b1;
						turn_top = 1'b1;
						if (s_reg.count != tocu_pkg::TOCU_BOTTOM)
						begin
							s_next.count = 8'(s_reg.count - 8'h01);
						end
					end
					else
					begin
						s_next.count = 8'(s_reg.count + 8'h01);
					end
				end
				else if (s_reg.count == tocu_pkg::TOCU_BOTTOM)
				begin
					s_next.down = 1'b0;
					s_next.count = 8'(s_reg.count + 8'h01);
				end
				else
				begin
					s_next.count = 8'(s_reg.count - 8'h01);
					if (s_reg.count == 8'h01)
					begin
						flag_set[tocu_pkg::TOCU_FLAG_OVF] = 1'b1;
					end
				end
			end
			else if ((s_next.wgm == tocu_pkg::TOCU_WGM_CTC) && match[0])
			begin
				s_next.count = tocu_pkg::TOCU_BOTTOM;
			end
			else
			begin
				s_next.count = 8'(s_reg.count + 8'h01);
				if (s_reg.count == tocu_pkg::TOCU_MAX)
				begin
					flag_set[tocu_pkg::TOCU_FLAG_OVF] = 1'b1;
				end
			end
		end
		if (!is_pc)
		begin
			s_next.down = 1'b0;
		end

		// CPU counter write wins over clear and count, blocks match on next tick
		if (wr_count)
		begin
			s_next.count = hwdata[7:0];
			s_next.block = 1'b1;
		end
		else if (timer_tick)
		begin
			s_next.block = 1'b0;
		end

		// Compare registers, buffer update at top or bottom
		for (int i = 0; i < 2; i++)
		begin
			if ((is_fast && restart) || (is_pc && turn_top))
			begin
				s_next.cmp[i] = s_reg.cbuf[i];
			end
			if (wr && (s_reg.ph_addr == ((i == 0) ? tocu_pkg::TOCU_ADDR_CMP_A : tocu_pkg::TOCU_ADDR_CMP_B)))
			begin
				s_next.cbuf[i] = hwdata[7:0];
				if (!is_pwm)
				begin
					s_next.cmp[i] = hwdata[7:0];
				end
			end
		end

		// Waveform generator per channel
		for (int i = 0; i < 2; i++)
		begin
			a = s_next.act[i];
			flag_set[tocu_pkg::TOCU_FLAG_A + i] = match[i];
			if (a != tocu_pkg::TOCU_ACT_NONE)
			begin
				if (!is_pwm)
				begin
					if (match[i] || force_hit[i])
					begin
						unique case (a)
							tocu_pkg::TOCU_ACT_TOGGLE: s_next.oc[i] = !s_reg.oc[i];
							tocu_pkg::TOCU_ACT_CLEAR: s_next.oc[i] = 1'b0;
							tocu_pkg::TOCU_ACT_SET: s_next.oc[i] = 1'b1;
							default: s_next.oc[i] = s_reg.oc[i];
						endcase
					end
				end
				else if (a == tocu_pkg::TOCU_ACT_TOGGLE)
				begin
					// Toggle in PWM only on channel A with compare-defined top
					if (match[i] && (i == 0) && s_next.wgm[2])
					begin
						s_next.oc[i] = !s_reg.oc[i];
					end
				end
				else if (is_fast)
				begin
					if (match[i])
					begin
						s_next.oc[i] = (a == tocu_pkg::TOCU_ACT_SET);
					end
					if (restart)
					begin
						s_next.oc[i] = (a == tocu_pkg::TOCU_ACT_CLEAR);
					end
				end
				else if (match[i])
				begin
					s_next.oc[i] = (a == tocu_pkg::TOCU_ACT_SET) ^ s_reg.down;
				end
			end
		end

		// Flags: hardware set wins over software or service clear
		if (wr && (s_reg.ph_addr == tocu_pkg::TOCU_ADDR_FLAGS))
		begin
			flag_clr = hwdata[2:0];
		end
		flag_clr[tocu_pkg::TOCU_FLAG_OVF] = flag_clr[tocu_pkg::TOCU_FLAG_OVF] || irq_ack.ovf;
		flag_clr[tocu_pkg::TOCU_FLAG_A] = flag_clr[tocu_pkg::TOCU_FLAG_A] || irq_ack.cmp_a;
		flag_clr[tocu_pkg::TOCU_FLAG_B] = flag_clr[tocu_pkg::TOCU_FLAG_B] || irq_ack.cmp_b;
		s_next.flags = (s_reg.flags & ~flag_clr) | flag_set;

		// Other writable registers
		if (wr && (s_reg.ph_addr == tocu_pkg::TOCU_ADDR_IRQ_EN))
		begin
			s_next.irqen = hwdata[2:0];
		end
		if (wr && (s_reg.ph_addr == tocu_pkg::TOCU_ADDR_PORT))
		begin
			s_next.port_data[0] = hwdata[tocu_pkg::TOCU_PORT_DATA_A];
			s_next.port_dir[0] = hwdata[tocu_pkg::TOCU_PORT_DIR_A];
			s_next.port_data[1] = hwdata[tocu_pkg::TOCU_PORT_DATA_B];
			s_next.port_dir[1] = hwdata[tocu_pkg::TOCU_PORT_DIR_B];
		end

		// Interrupt requests
		s_next.irq.ovf = s_next.flags[tocu_pkg::TOCU_FLAG_OVF] && s_next.irqen[tocu_pkg::TOCU_FLAG_OVF];
		s_next.irq.cmp_a = s_next.flags[tocu_pkg::TOCU_FLAG_A] && s_next.irqen[tocu_pkg::TOCU_FLAG_A];
		s_next.irq.cmp_b = s_next.flags[tocu_pkg::TOCU_FLAG_B] && s_next.irqen[tocu_pkg::TOCU_FLAG_B];

		// Port override, independent of waveform mode
		for (int i = 0; i < 2; i++)
		begin
			s_next.pins.out[i] = (s_next.act[i] != tocu_pkg::TOCU_ACT_NONE) ? s_next.oc[i] : s_next.port_data[i];
			s_next.pins.oe_n[i] = !s_next.port_dir[i];
		end

		// AHB-Lite address phase; read data taken from next state
		if (hready)
		begin
			s_next.ph_valid = hsel && htrans[1] && (hsize == tocu_pkg::TOCU_HSIZE_WORD);
			s_next.ph_write = hwrite;
			s_next.ph_addr = {haddr[7:2], 2'b00};
			if (hsel && htrans[1] && !hwrite)
			begin
				s_next.hrdata = reg_read(s_next, {haddr[7:2], 2'b00});
			end
		end
		s_next.hreadyout = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_reg <= tocu_pkg::TOCU_STATE_RESET;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign hreadyout = s_reg.hreadyout;
	assign hresp = 1'b0;
	assign hrdata = s_reg.hrdata;
	assign irq_req = s_reg.irq;
	assign pins = s_reg.pins;

endmodule
`default_nettype wire

/* logic/tocu_pkg.sv */
// Purpose: Shared constants and types for the timer output compare unit
// Assumes: AHB-Lite register window of 256 bytes, one word per register
// Notes: Offsets are byte addresses within the window
`default_nettype none
package tocu_pkg;
	// Register byte offsets
	localparam logic [7:0] TOCU_ADDR_CTRL = 8'h00;
	localparam logic [7:0] TOCU_ADDR_COUNT = 8'h04;
	localparam logic [7:0] TOCU_ADDR_CMP_A = 8'h08;
	localparam logic [7:0] TOCU_ADDR_CMP_B = 8'h0C;
	localparam logic [7:0] TOCU_ADDR_FLAGS = 8'h10;
	localparam logic [7:0] TOCU_ADDR_IRQ_EN = 8'h14;
	localparam logic [7:0] TOCU_ADDR_PORT = 8'h18;
	// Control register fields
	localparam int TOCU_CTRL_WGM_LSB = 0;
	localparam int TOCU_CTRL_ACT_A_LSB = 4;
	localparam int TOCU_CTRL_ACT_B_LSB = 6;
	localparam int TOCU_CTRL_FORCE_A = 8;
	localparam int TOCU_CTRL_FORCE_B = 9;
	// Flag and interrupt enable fields
	localparam int TOCU_FLAG_OVF = 0;
	localparam int TOCU_FLAG_A = 1;
	localparam int TOCU_FLAG_B = 2;
	// Port register fields
	localparam int TOCU_PORT_DATA_A = 0;
	localparam int TOCU_PORT_DIR_A = 1;
	localparam int TOCU_PORT_DATA_B = 2;
	localparam int TOCU_PORT_DIR_B = 3;
	// Waveform modes
	localparam logic [2:0] TOCU_WGM_NORMAL = 3'h0;
	localparam logic [2:0] TOCU_WGM_PC_MAX = 3'h1;
	localparam logic [2:0] TOCU_WGM_CTC = 3'h2;
	localparam logic [2:0] TOCU_WGM_FAST_MAX = 3'h3;
	localparam logic [2:0] TOCU_WGM_PC_CMP = 3'h5;
	localparam logic [2:0] TOCU_WGM_FAST_CMP = 3'h7;
	// Output actions
	localparam logic [1:0] TOCU_ACT_NONE = 2'h0;
	localparam logic [1:0] TOCU_ACT_TOGGLE = 2'h1;
	localparam logic [1:0] TOCU_ACT_CLEAR = 2'h2;
	localparam logic [1:0] TOCU_ACT_SET = 2'h3;
	// Counter limits and reset values
	localparam logic [7:0] TOCU_MAX = 8'hFF;
	localparam logic [7:0] TOCU_BOTTOM = 8'h00;
	localparam logic [7:0] TOCU_COUNT_RESET = 8'h00;
	localparam logic [7:0] TOCU_CMP_RESET = 8'h00;
	localparam logic [1:0] TOCU_OC_RESET = 2'h0;
	localparam logic [2:0] TOCU_HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic ovf;
		logic cmp_b;
		logic cmp_a;
	} tocu_irq_t;

	typedef struct packed {
		logic [1:0] out;
		logic [1:0] oe_n;
	} tocu_pins_t;

	typedef struct packed {
		logic [2:0] wgm;
		logic [1:0][1:0] act;
		logic [7:0] count;
		logic down;
		logic [1:0][7:0] cmp;
		logic [1:0][7:0] cbuf;
		logic [2:0] flags;
		logic [2:0] irqen;
		logic [1:0] port_data;
		logic [1:0] port_dir;
		logic [1:0] oc;
		logic block;
		logic ph_valid;
		logic ph_write;
		logic [7:0] ph_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		tocu_irq_t irq;
		tocu_pins_t pins;
	} tocu_state_t;

	localparam tocu_state_t TOCU_STATE_RESET = '{
		wgm: TOCU_WGM_NORMAL,
		act: {TOCU_ACT_NONE, TOCU_ACT_NONE},
		count: TOCU_COUNT_RESET,
		down: 1'b0,
		cmp: {TOCU_CMP_RESET, TOCU_CMP_RESET},
		cbuf: {TOCU_CMP_RESET, TOCU_CMP_RESET},
		flags: 3'h0,
		irqen: 3'h0,
		port_data: 2'h0,
		port_dir: 2'h0,
		oc: TOCU_OC_RESET,
		block: 1'b0,
		ph_valid: 1'b0,
		ph_write: 1'b0,
		ph_addr: 8'h00,
		hrdata: 32'h0000_0000,
		hreadyout: 1'b1,
		irq: '{ovf: 1'b0, cmp_b: 1'b0, cmp_a: 1'b0},
		pins: '{out: 2'h0, oe_n: 2'h3}
	};
endpackage
`default_nettype wire

/* sim/tocu_monitor.sv */
// Purpose: Port level checks of the timer compare block
// Assumes: One zero-wait slave, hready tied to hreadyout
// Notes: Outputs may only move for a tick, a write, a read or a service acknowledge
`default_nettype none
module tocu_monitor
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Timer, interrupts and pins
	input wire logic timer_tick,
	input wire tocu_pkg::tocu_irq_t irq_ack,
	input wire tocu_pkg::tocu_irq_t irq_req,
	input wire tocu_pkg::tocu_pins_t pins
);
	wire ap = hsel && htrans[1] && hready;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_zero_wait: assert property (hreadyout)
		else $error("wait state inserted");
	a_okay_resp: assert property (!hresp)
		else $error("error response");
	a_reset_state: assert property ($rose(hresetn) |-> pins == 4'h3 && irq_req == 3'h0)
		else $error("state not cleared by reset");
	a_irq_clear: assert property (|($past(irq_req) & ~irq_req) |-> |$past(irq_ack) || $past(ap && hwrite, 2))
		else $error("request dropped without cause");
	a_irq_raise: assert property (|(irq_req & ~$past(irq_req)) |-> $past(timer_tick) || $past(ap && hwrite, 2))
		else $error("request raised without cause");
	a_out_move: assert property ($changed(pins.out) |-> $past(timer_tick) || $past(ap && hwrite, 2))
		else $error("output moved without cause");
	a_dir_move: assert property ($changed(pins.oe_n) |-> $past(ap && hwrite, 2))
		else $error("direction moved without write");
	a_rdata_hold: assert property ($changed(hrdata) |-> $past(ap && !hwrite))
		else $error("read data moved without read");
endmodule
bind tocu_timer_compare tocu_monitor tocu_monitor_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .timer_tick, .irq_ack, .irq_req, .pins);
`default_nettype wire

/* sim/tocu_port_model.sv */
// Purpose: Pad logic beside the compare outputs
// Assumes: Pads carry a pull-up
// Notes: A released pad reads high, never the last driven level
`default_nettype none
module tocu_port_model
(
	// Block side
	input wire tocu_pkg::tocu_pins_t pins,
	// Pad levels
	output logic [1:0] pad
);
	assign pad = pins.out | pins.oe_n;
endmodule
`default_nettype wire

/* sim/tocu_timer_compare_bench.sv */
// Purpose: Self-checking bench of the timer compare block
// Assumes: Registers at the offsets of the package
// Notes: Ticks are single pulses so every count step is known
`default_nettype none
module tocu_timer_compare_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic timer_tick = 1'b0;
	tocu_pkg::tocu_irq_t irq_ack = 3'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	tocu_pkg::tocu_irq_t irq_req;
	tocu_pkg::tocu_pins_t pins;
	logic [1:0] pad;
	int err_count = 0;
	int checked = 0;
	always #5 hclk = ~hclk;
	tocu_timer_compare tocu_timer_compare_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .timer_tick, .irq_ack, .irq_req, .pins);
	tocu_port_model tocu_port_model_inst (.pins, .pad);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Waits on hready without limit; only the watchdog ends a hang
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask
	// Compares pad levels, pin values and enables together
	task automatic pinc(input logic [5:0] e);
		@(negedge hclk);
		chk({26'h0, pad, pins}, {26'h0, e});
	endtask
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge hclk);
			timer_tick <= 1'b1;
			@(posedge hclk);
			timer_tick <= 1'b0;
		end
	endtask
	task automatic s_reset();
		rdc(8'h00, 32'h0000_0000);
		rdc(8'h04, 32'h0000_0000);
		rdc(8'h1C, 32'h0000_0000);
		pinc(6'h33);
	endtask
	task automatic s_overflow();
		wr(8'h04, 32'h0000_00FE);
		tick(1);
		rdc(8'h04, 32'h0000_00FF);
		tick(1);
		rdc(8'h04, 32'h0000_0000);
		rdc(8'h10, 32'h0000_0001);
		wr(8'h10, 32'h0000_0001);
		rdc(8'h10, 32'h0000_0000);
	endtask
	task automatic s_match();
		wr(8'h08, 32'h0000_0010);
		wr(8'h0C, 32'h0000_0012);
		wr(8'h14, 32'h0000_0002);
		wr(8'h04, 32'h0000_0010);
		tick(1);
		rdc(8'h10, 32'h0000_0000);
		wr(8'h04, 32'h0000_000F);
		tick(2);
		@(negedge hclk);
		chk({29'h0, irq_req}, 32'h0000_0001);
		@(posedge hclk);
		irq_ack <= 3'h1;
		@(posedge hclk);
		irq_ack <= 3'h0;
		rdc(8'h10, 32'h0000_0000);
		tick(2);
		rdc(8'h10, 32'h0000_0004);
		chk({29'h0, irq_req}, 32'h0000_0000);
		wr(8'h14, 32'h0000_0000);
		wr(8'h10, 32'h0000_0007);
	endtask
	task automatic s_force();
		logic [1:0] act[4] = '{2'h3, 2'h1, 2'h2, 2'h1};
		logic oc[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h00, {22'h0, 2'h1, 2'h0, act[i], 4'h0});
			pinc({3'h6, oc[i], 2'h3});
		end
		rdc(8'h10, 32'h0000_0000);
		rdc(8'h04, 32'h0000_0013);
		wr(8'h00, 32'h0000_0100);
		wr(8'h18, 32'h0000_0002);
		pinc(6'h22);
		wr(8'h00, 32'h0000_0033);
		pinc(6'h36);
	endtask
	task automatic s_buffer();
		wr(8'h08, 32'h0000_0040);
		rdc(8'h08, 32'h0000_0040);
		wr(8'h04, 32'h0000_003F);
		tick(2);
		rdc(8'h10, 32'h0000_0000);
		wr(8'h04, 32'h0000_00FF);
		tick(1);
		wr(8'h10, 32'h0000_0007);
		wr(8'h04, 32'h0000_003F);
		tick(2);
		rdc(8'h10, 32'h0000_0002);
	endtask
	task automatic s_ctc();
		wr(8'h00, 32'h0000_0012);
		wr(8'h10, 32'h0000_0007);
		wr(8'h08, 32'h0000_0003);
		wr(8'h04, 32'h0000_0000);
		tick(4);
		rdc(8'h04, 32'h0000_0000);
		rdc(8'h10, 32'h0000_0002);
		pinc(6'h22);
	endtask
	// Phase correct: buffer loads at top, then counts down
	task automatic s_phase();
		wr(8'h00, 32'h0000_0001);
		wr(8'h10, 32'h0000_0007);
		wr(8'h08, 32'h0000_0020);
		wr(8'h04, 32'h0000_00FE);
		tick(2);
		rdc(8'h04, 32'h0000_00FE);
		wr(8'h04, 32'h0000_0021);
		tick(2);
		rdc(8'h04, 32'h0000_001F);
		rdc(8'h10, 32'h0000_0002);
	endtask
	task automatic complete_run();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#200000;
		err_count++;
		complete_run();
	end
	initial
	begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		s_reset();
		s_overflow();
		s_match();
		s_force();
		s_buffer();
		s_ctc();
		s_phase();
		complete_run();
	end
endmodule
`default_nettype wire
